// ---- verilog/spf_pkg.sv ----
// Shared constants for the serial port: register map, bit positions, reset values and rates.
package spf_pkg;

    // Register offsets as seen on the register port.
    localparam logic [7:0] CTRL_OFS   = 8'h10;  // Port control register.
    localparam logic [7:0] STAT_OFS   = 8'h11;  // Port status and control register.
    localparam logic [7:0] DATA_OFS   = 8'h12;  // Serial data buffer.

    // Field positions in the port control register.
    localparam int CTRL_RIE_BIT  = 7;  // Receive-full request enable.
    localparam int CTRL_MSTR_BIT = 5;  // Master select bit.
    localparam int CTRL_CLOCK_POLARITY_SELECT_BIT = 4;  // Clock polarity select.
    localparam int CTRL_CLOCK_PHASE_SELECT_BIT = 3;  // Clock phase select.
    localparam int CTRL_SPE_BIT  = 1;  // Port enable bit.

    // Field positions in the port status and control register.
    localparam int STAT_RXF_BIT  = 7;  // Receive full flag, read only.
    localparam int STAT_ERROR_INTERRUPT_ENABLE_BIT = 6; // Error request enable.
    localparam int STAT_OVR_BIT  = 5;  // Overflow flag, read only.
    localparam int STAT_MODE_FAULT_FLAG_BIT = 4;  // Mode fault flag, read only.
    localparam int STAT_TXE_BIT  = 3;  // Transmitter empty flag, read only.
    localparam int STAT_MFEN_BIT = 2;  // Mode fault enable.
    localparam int STAT_DIV_LSB  = 0;  // Low bit of the two-bit rate divider field.

    // Reset values of the writable control fields.
    localparam logic [7:0] CTRL_RESET = 8'h08;  // Phase select 1, everything else clear.
    localparam logic [3:0] STAT_RESET = 4'h0;   // Error enable, fault enable and divider clear.

    // Half bit periods in bus cycles for the divide ratios 2, 8, 32 and 128.
    localparam logic [6:0] HALF_DIV2   = 7'h01;
    localparam logic [6:0] HALF_DIV8   = 7'h04;
    localparam logic [6:0] HALF_DIV32  = 7'h10;
    localparam logic [6:0] HALF_DIVIDE_BY_128 = 7'h40;

    // Edges in one byte and the number of bits in a byte.
    localparam logic [4:0] EDGES_PER_BYTE = 5'h10;
    localparam logic [3:0] BITS_PER_BYTE  = 4'h8;

endpackage : spf_pkg

// ---- verilog/spf_baud.sv ----
// Free-running rate divider that gives one pulse every half bit period.
`timescale 1ns/1ps
module spf_baud (
    input  wire logic       clk_in,        // Bus clock.
    input  wire logic       rst_n_in,      // Synchronised reset, active low.
    input  wire logic       en_in,         // Runs only while enabled as master.
    input  wire logic [1:0] sel_in,        // Rate divider field.
    output logic            half_tick_out  // One-cycle pulse per half bit period.
);

    logic [6:0] cnt_q;   // Cycles counted in the current half period.
    logic [6:0] half;    // Length of a half period for the chosen rate.

    // Half period lookup from the divider field.
    always_comb begin
        case (sel_in)
            2'd0:    half = spf_pkg::HALF_DIV2;
            2'd1:    half = spf_pkg::HALF_DIV8;
            2'd2:    half = spf_pkg::HALF_DIV32;
            default: half = spf_pkg::HALF_DIVIDE_BY_128;
        endcase
    end

    // The counter runs freely, so a write lands anywhere within the period.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt_q         <= 7'h00;
            half_tick_out <= 1'b0;
        end else if (!en_in) begin
            cnt_q         <= 7'h00;  // Stopped to save power when not a live master.
            half_tick_out <= 1'b0;
        end else if (cnt_q >= half - 7'h01) begin
            cnt_q         <= 7'h00;
            half_tick_out <= 1'b1;
        end else begin
            cnt_q         <= cnt_q + 7'h01;
            half_tick_out <= 1'b0;
        end
    end

endmodule : spf_baud

// ---- verilog/spf_shift.sv ----
// Eight-bit shift engine shared by the master and slave roles.
`timescale 1ns/1ps
module spf_shift (
    input  wire logic       clk_in,      // Bus clock.
    input  wire logic       rst_n_in,    // Synchronised reset, active low.
    input  wire logic       abort_in,    // Clears the engine and its counters.
    input  wire logic       load_in,     // Loads a new byte to send.
    input  wire logic [7:0] load_data_in,// Byte to send.
    input  wire logic       lead_in,     // Leading serial clock edge.
    input  wire logic       trail_in,    // Trailing serial clock edge.
    input  wire logic       clock_phase_select_in,     // Clock phase select.
    input  wire logic       din_in,      // Serial input bit.
    output logic            dout_out,    // Serial output bit.
    output logic [7:0]      data_out,    // Shift register contents.
    output logic            first_out,   // Pulse after the first capture of a byte.
    output logic            done_out,    // Pulse after the eighth capture.
    output logic            end_out      // Pulse after the eighth trailing edge.
);

    logic [3:0] scnt_q;   // Captures done in this byte.
    logic [3:0] tcnt_q;   // Trailing edges seen in this byte.
    logic       samp;     // Capture edge for the chosen phase.
    logic       drive;    // Output change edge for the chosen phase.
    logic       last_t;   // This trailing edge closes the byte.

    assign samp   = clock_phase_select_in ? trail_in : lead_in;
    assign drive  = clock_phase_select_in ? lead_in : trail_in;
    assign last_t = trail_in && (tcnt_q == spf_pkg::BITS_PER_BYTE - 4'h1);

    // Shift register: most significant bit first, in and out together.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            data_out <= 8'h00;
            dout_out <= 1'b0;
        end else if (abort_in) begin
            data_out <= 8'h00;
            dout_out <= 1'b0;
        end else if (load_in) begin
            data_out <= load_data_in;
            dout_out <= load_data_in[7];  // Phase 0 needs the first bit before any edge.
        end else begin
            if (samp) begin
                data_out <= {data_out[6:0], din_in};
            end
            if (drive) begin
                dout_out <= data_out[7];
            end
        end
    end

    // Capture and edge counters with their completion pulses.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            scnt_q    <= 4'h0;
            tcnt_q    <= 4'h0;
            first_out <= 1'b0;
            done_out  <= 1'b0;
            end_out   <= 1'b0;
        end else if (abort_in || load_in) begin
            scnt_q    <= 4'h0;
            tcnt_q    <= 4'h0;
            first_out <= 1'b0;
            done_out  <= 1'b0;
            end_out   <= 1'b0;
        end else begin
            first_out <= samp && (scnt_q == 4'h0);
            done_out  <= samp && (scnt_q == spf_pkg::BITS_PER_BYTE - 4'h1);
            end_out   <= last_t;
            if (last_t) begin
                scnt_q <= 4'h0;  // Ready for a following byte with no reload.
                tcnt_q <= 4'h0;
            end else begin
                scnt_q <= samp ? scnt_q + 4'h1 : scnt_q;
                tcnt_q <= trail_in ? tcnt_q + 4'h1 : tcnt_q;
            end
        end
    end

endmodule : spf_shift

// ---- verilog/spf_top.sv ----
// Byte-wide full-duplex serial port with master timing, overflow and mode fault handling.
`timescale 1ns/1ps
module spf_top (
    input  wire logic       mclk_in,     // Bus clock, 10 MHz.
    input  wire logic       rstn_in,     // System reset, active low.
    input  wire logic [7:0] addr_in,     // Register address.
    input  wire logic [7:0] wdata_in,    // Register write data.
    input  wire logic       wr_in,       // Write strobe.
    input  wire logic       rd_in,       // Read strobe.
    output logic [7:0]      rdata_out,   // Read data, valid the cycle after the strobe.
    input  wire logic       sck_in,      // Serial clock pin level.
    output logic            sck_out,     // Serial clock driven as master.
    output logic            sck_oe_out,  // Serial clock drive enable.
    input  wire logic       mosi_in,     // Master-out pin level.
    output logic            mosi_out,    // Master-out data.
    output logic            mosi_oe_out, // Master-out drive enable.
    input  wire logic       miso_in,     // Master-in pin level.
    output logic            miso_out,    // Slave-out data.
    output logic            miso_oe_out, // Slave-out drive enable.
    input  wire logic       ss_n_in,     // Slave select pin, active low.
    output logic            irq_out      // Shared receive and error request.
);

    // Reset release chain.
    logic       rst_meta_q;  // First stage of the reset release.
    logic       rst_n;       // Released reset used everywhere else.

    // Software visible state.
    logic [7:0] ctrl_q;      // Port control register.
    logic       error_interrupt_enable_q;     // Error request enable.
    logic       mfen_q;      // Mode fault enable.
    logic [1:0] div_q;       // Rate divider field.
    logic [7:0] txbuf_q;     // Byte waiting to be sent.
    logic [7:0] rxbuf_q;     // Last byte received while receive full was clear.
    logic       txe_q;       // Transmitter empty flag.
    logic       rxf_q;       // Receive full flag.
    logic       ovr_q;       // Overflow flag.
    logic       mode_fault_flag_q;      // Mode fault flag.
    logic       rxf_arm_q;   // Status read seen with receive full or overflow set.
    logic       mode_fault_flag_arm_q;  // Status read seen with a clean fault sequence.

    // Master sequencing.
    logic       run_q;       // Master transfer in progress.
    logic [4:0] mec_q;       // Master edges issued in this byte.
    logic       msck_q;      // Master serial clock level.
    logic       half_tick;   // Half bit pulse from the divider.

    // Slave tracking.
    logic       sck_prev_q;  // Serial clock level one cycle ago.
    logic       ss_prev_q;   // Select level one cycle ago.
    logic       sbusy_q;     // Slave transfer in progress.

    // Decoded and combined signals.
    logic       port_enable_bit, mstr, clock_polarity_select, clock_phase_select;     // Control fields.
    logic       m_live;                   // Enabled as master.
    logic       s_live;                   // Enabled as slave.
    logic       m_start;                  // Master begins a byte this cycle.
    logic       m_edge;                   // Master issues a clock edge this cycle.
    logic       m_lead;                   // That edge is a leading one.
    logic       s_lead, s_trail;          // Qualified slave edges.
    logic       lead, trail;              // Edges fed to the shift engine.
    logic       load;                     // Shift engine load.
    logic       abort;                    // Shift engine clear.
    logic       m_fault;                  // Master fault condition.
    logic       s_fault;                  // Slave fault condition.
    logic       fault_set;                // Fault flag sets this cycle.
    logic       wr_ctrl, wr_stat, wr_data;// Write decodes.
    logic       rd_stat, rd_data;         // Read decodes.
    logic       sh_first, sh_done, sh_end;// Shift engine pulses.
    logic       sh_dout;                  // Shift engine output bit.
    logic [7:0] sh_data;                  // Shift engine contents.

    // Detects a move of the serial clock from one level to the other.
    function automatic logic edge_to(input logic prev, input logic now, input logic level);
        edge_to = (prev != level) && (now == level);
    endfunction : edge_to

    // Reset asserts at once and is released after two clock edges.
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rst_meta_q <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n      <= rst_meta_q;
        end
    end

    // Field decodes and the live role.
    assign port_enable_bit    = ctrl_q[spf_pkg::CTRL_SPE_BIT];
    assign mstr   = ctrl_q[spf_pkg::CTRL_MSTR_BIT];
    assign clock_polarity_select   = ctrl_q[spf_pkg::CTRL_CLOCK_POLARITY_SELECT_BIT];
    assign clock_phase_select   = ctrl_q[spf_pkg::CTRL_CLOCK_PHASE_SELECT_BIT];
    assign m_live = port_enable_bit && mstr;
    assign s_live = port_enable_bit && !mstr;

    // Register port decodes.
    assign wr_ctrl = wr_in && (addr_in == spf_pkg::CTRL_OFS);
    assign wr_stat = wr_in && (addr_in == spf_pkg::STAT_OFS);
    assign wr_data = wr_in && (addr_in == spf_pkg::DATA_OFS);
    assign rd_stat = rd_in && (addr_in == spf_pkg::STAT_OFS);
    assign rd_data = rd_in && (addr_in == spf_pkg::DATA_OFS);

    // Fault conditions: select low on a master, select rising mid transfer on a slave.
    assign m_fault   = m_live && !ss_n_in;
    assign s_fault   = s_live && sbusy_q && ss_n_in;
    assign fault_set = mfen_q && (m_fault || s_fault);

    // The bit clock divider runs only for a live master.
    spf_baud u_baud (
        .clk_in       (mclk_in),
        .rst_n_in     (rst_n),
        .en_in        (m_live),
        .sel_in       (div_q),
        .half_tick_out(half_tick)
    );

    // A master starts on a half bit pulse once software has queued a byte.
    assign m_start = m_live && !txe_q && half_tick && !fault_set
                     && (!run_q || (mec_q == spf_pkg::EDGES_PER_BYTE));
    assign m_edge  = (m_start && clock_phase_select)
                     || (run_q && half_tick && (mec_q != spf_pkg::EDGES_PER_BYTE) && !m_start);
    assign m_lead  = m_start ? 1'b1 : !mec_q[0];

    // Slave edges only count while selected.
    assign s_lead  = s_live && !ss_n_in && edge_to(sck_prev_q, sck_in, !clock_polarity_select);
    assign s_trail = s_live && !ss_n_in && edge_to(sck_prev_q, sck_in, clock_polarity_select);

    // Engine inputs follow the live role.
    assign lead  = mstr ? (m_edge && m_lead) : s_lead;
    assign trail = mstr ? (m_edge && !m_lead) : s_trail;
    assign load  = m_start || (s_live && !sbusy_q && !txe_q);
    assign abort = !port_enable_bit || (m_fault && mfen_q);

    // Shared shift engine.
    spf_shift u_shift (
        .clk_in      (mclk_in),
        .rst_n_in    (rst_n),
        .abort_in    (abort),
        .load_in     (load),
        .load_data_in(txbuf_q),
        .lead_in     (lead),
        .trail_in    (trail),
        .clock_phase_select_in     (clock_phase_select),
        .din_in      (mstr ? miso_in : mosi_in),
        .dout_out    (sh_dout),
        .data_out    (sh_data),
        .first_out   (sh_first),
        .done_out    (sh_done),
        .end_out     (sh_end)
    );

    // Port control register; a master fault drops only the enable bit.
    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= spf_pkg::CTRL_RESET;
        end else if (mfen_q && m_fault) begin
            ctrl_q[spf_pkg::CTRL_SPE_BIT] <= 1'b0;
        end else if (wr_ctrl) begin
            ctrl_q <= wdata_in;
        end
    end

    // Writable fields of the status and control register.
    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            {error_interrupt_enable_q, mfen_q, div_q} <= spf_pkg::STAT_RESET;
        end else if (wr_stat) begin
            error_interrupt_enable_q <= wdata_in[spf_pkg::STAT_ERROR_INTERRUPT_ENABLE_BIT];
            mfen_q  <= wdata_in[spf_pkg::STAT_MFEN_BIT];
            div_q   <= wdata_in[spf_pkg::STAT_DIV_LSB +: 2];
        end
    end

    // Transmit buffer and its empty flag.
    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            txbuf_q <= 8'h00;
            txe_q   <= 1'b1;
        end else begin
            if (wr_data) begin
                txbuf_q <= wdata_in;
            end
            if (!port_enable_bit || load || (mfen_q && m_fault)) begin
                txe_q <= 1'b1;
            end else if (wr_data) begin
                txe_q <= 1'b0;
            end
        end
    end

    // Master sequencer: one half period idle or one edge per half tick, sixteen edges a byte.
    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            run_q  <= 1'b0;
            mec_q  <= 5'h00;
            msck_q <= 1'b0;
        end else if (!m_live || abort) begin
            run_q  <= 1'b0;
            mec_q  <= 5'h00;
            msck_q <= clock_polarity_select;
        end else if (m_start) begin
            run_q  <= 1'b1;
            mec_q  <= clock_phase_select ? 5'h01 : 5'h00;
            msck_q <= clock_phase_select ? !clock_polarity_select : clock_polarity_select;
        end else if (run_q && half_tick) begin
            if (mec_q == spf_pkg::EDGES_PER_BYTE) begin
                run_q  <= 1'b0;
                msck_q <= clock_polarity_select;
            end else begin
                mec_q  <= mec_q + 5'h01;
                msck_q <= !msck_q;
            end
        end
    end

    // Slave transfer window used for fault detection.
    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            sck_prev_q <= 1'b0;
            ss_prev_q  <= 1'b1;
            sbusy_q    <= 1'b0;
        end else begin
            sck_prev_q <= sck_in;
            ss_prev_q  <= ss_n_in;
            if (!s_live || ss_n_in) begin
                sbusy_q <= 1'b0;
            end else if (!clock_phase_select && ss_prev_q) begin
                sbusy_q <= 1'b1;
            end else if (clock_phase_select && s_lead) begin
                sbusy_q <= 1'b1;
            end else if (sh_end) begin
                sbusy_q <= 1'b0;
            end
        end
    end

    // Receive buffer, receive full and overflow.
    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            rxbuf_q   <= 8'h00;
            rxf_q     <= 1'b0;
            ovr_q     <= 1'b0;
            rxf_arm_q <= 1'b0;
        end else begin
            if (sh_done && !rxf_q) begin
                rxbuf_q <= sh_data;
            end
            if (rd_stat) begin
                rxf_arm_q <= rxf_q || ovr_q;
            end else if (rd_data) begin
                rxf_arm_q <= 1'b0;
            end
            if (sh_done) begin
                rxf_q <= 1'b1;  // Set wins over a clear in the same cycle.
            end else if (rd_data && rxf_arm_q) begin
                rxf_q <= 1'b0;
            end
            if (sh_first && rxf_q) begin
                ovr_q <= 1'b1;
            end else if (rd_data && rxf_arm_q) begin
                ovr_q <= 1'b0;
            end
        end
    end

    // Mode fault flag and its two-step clear.
    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            mode_fault_flag_q     <= 1'b0;
            mode_fault_flag_arm_q <= 1'b0;
        end else begin
            if (fault_set) begin
                mode_fault_flag_q     <= 1'b1;
                mode_fault_flag_arm_q <= 1'b0;
            end else if (rd_stat) begin
                mode_fault_flag_arm_q <= mode_fault_flag_q;
            end else if (wr_ctrl && mode_fault_flag_arm_q) begin
                mode_fault_flag_q     <= 1'b0;
                mode_fault_flag_arm_q <= 1'b0;
            end
        end
    end

    // Shared request line for receive, overflow and fault.
    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= (rxf_q && port_enable_bit && ctrl_q[spf_pkg::CTRL_RIE_BIT])
                       || (error_interrupt_enable_q && (ovr_q || mode_fault_flag_q));
        end
    end

    // Pin drivers; a dead port hands every pin back to the shared port.
    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            sck_out     <= 1'b0;
            sck_oe_out  <= 1'b0;
            mosi_out    <= 1'b0;
            mosi_oe_out <= 1'b0;
            miso_out    <= 1'b0;
            miso_oe_out <= 1'b0;
        end else begin
            sck_out     <= run_q ? msck_q : clock_polarity_select;
            sck_oe_out  <= m_live && !fault_set;
            mosi_out    <= sh_dout;
            mosi_oe_out <= m_live && !fault_set;
            miso_out    <= sh_dout;
            miso_oe_out <= s_live && !ss_n_in;
        end
    end

    // Registered read data, zero for unmapped addresses.
    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            rdata_out <= 8'h00;
        end else if (rd_in) begin
            case (addr_in)
                spf_pkg::CTRL_OFS: rdata_out <= ctrl_q;
                spf_pkg::STAT_OFS: rdata_out <= {rxf_q, error_interrupt_enable_q, ovr_q, mode_fault_flag_q, txe_q, mfen_q, div_q};
                spf_pkg::DATA_OFS: rdata_out <= rxbuf_q;
                default:           rdata_out <= 8'h00;
            endcase
        end else begin
            rdata_out <= 8'h00;
        end
    end

endmodule : spf_top

// ---- verification/spf_props.sv ----
// Port assertions for the serial port.
`timescale 1ns/1ps
module spf_props (
    input wire logic       mclk_in,     // Bus clock.
    input wire logic       rstn_in,     // Reset, active low.
    input wire logic [7:0] addr_in,     // Address.
    input wire logic       rd_in,       // Read strobe.
    input wire logic [7:0] rdata_out,   // Read data.
    input wire logic       sck_oe_out,  // Clock drive enable.
    input wire logic       mosi_out,    // Master data.
    input wire logic       mosi_oe_out, // Master data enable.
    input wire logic       miso_oe_out, // Slave data enable.
    input wire logic       ss_n_in,     // Select, active low.
    input wire logic       irq_out      // Request.
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rstn_in);
    AST_RD_IDLE: assert property (!$past(rd_in) |-> rdata_out == 8'h00) else $error("rdata not idle");
    AST_UNMAPPED: assert property ($past(rd_in) && $past(addr_in[7:2]) != 6'h04 |-> rdata_out == 8'h00)
        else $error("unmapped read data");
    AST_MISO_SEL: assert property (miso_oe_out |-> !$past(ss_n_in)) else $error("miso driven unselected");
    AST_DESEL: assert property (ss_n_in |=> !miso_oe_out) else $error("miso not floated");
    AST_ONE_DRV: assert property (!(miso_oe_out && mosi_oe_out)) else $error("both data drivers");
    AST_SCK_OWN: assert property (sck_oe_out |-> mosi_oe_out && $past(ss_n_in)) else $error("clock drive misplaced");
    AST_IRQ_QUIET: assert property ($rose(rstn_in) |-> !irq_out [*3]) else $error("request after reset");
    AST_MOSI_OWN: assert property ($changed(mosi_out) |-> mosi_oe_out || $past(mosi_oe_out))
        else $error("mosi moved undriven");
endmodule : spf_props
bind spf_top spf_props u_props (.mclk_in, .rstn_in, .addr_in, .rd_in, .rdata_out, .sck_oe_out, .mosi_out,
    .mosi_oe_out, .miso_oe_out, .ss_n_in, .irq_out);

// ---- verification/spf_peer.sv ----
// Far-side slave model: clock idle low, phase 1, msb first.
`timescale 1ns/1ps
module spf_peer (
    input  wire logic       sck_in,   // Serial clock.
    input  wire logic       mosi_in,  // Data from master.
    input  wire logic [7:0] tx_in,    // Byte to return.
    output logic            miso_out, // Data to master.
    output logic [7:0]      rx_out    // Last byte received.
);
    int         n = 0;  // Bits captured in this byte.
    logic [7:0] sh;     // Receive shift register.
    initial miso_out = 1'b0;
    // Leading edge opens a bit.
    always @(posedge sck_in) miso_out <= tx_in[7 - n];
    // Trailing edge captures; after a byte the line changes so stale data never looks valid.
    always @(negedge sck_in) if ($time > 0) begin
        sh = {sh[6:0], mosi_in};
        n = n + 1;
        if (n == 8) begin
            rx_out = sh;
            n = 0;
            miso_out <= ~miso_out;
        end
    end
endmodule : spf_peer

// ---- verification/tb.sv ----
// Self-checking bench for the serial port.
`timescale 1ns/1ps
module tb;
    localparam logic [7:0] C = spf_pkg::CTRL_OFS, S = spf_pkg::STAT_OFS, D = spf_pkg::DATA_OFS;
    logic clk, rstn, wr, rd, ss_n, sck, sck_oe, mosi, mosi_oe, miso, miso_oe, pmiso, irq;
    logic [7:0] addr, wdata, rdata, prx, d;
    int err_count, checks, i;
    wire sck_w = sck_oe & sck;  // Released clock and master-out lines are pulled low.
    wire mosi_w = mosi_oe & mosi;
    wire miso_w = miso_oe ? miso : pmiso;
    spf_top uut (.mclk_in(clk), .rstn_in(rstn), .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
        .rdata_out(rdata), .sck_in(sck_w), .sck_out(sck), .sck_oe_out(sck_oe), .mosi_in(mosi_w), .mosi_out(mosi),
        .mosi_oe_out(mosi_oe), .miso_in(miso_w), .miso_out(miso), .miso_oe_out(miso_oe), .ss_n_in(ss_n),
        .irq_out(irq));
    spf_peer peer (.sck_in(sck_w), .mosi_in(mosi_w), .tx_in(8'h3C), .miso_out(pmiso), .rx_out(prx));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task give_verdict;
        $display("errors %0d checks %0d", err_count, checks);
        if (err_count == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : give_verdict
    task chk(input string n, input logic [7:0] e, input logic [7:0] s);
        checks++;
        if (s !== e) begin
            $display("ERROR %s expected %h seen %h", n, e, s);
            err_count++;
        end
    endtask : chk
    task wrr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk) begin addr <= a; wdata <= v; wr <= 1'b1; end
        @(posedge clk) wr <= 1'b0;
    endtask : wrr
    task rdc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e, input string n);
        @(posedge clk) begin addr <= a; rd <= 1'b1; end
        @(posedge clk) rd <= 1'b0;
        #1 d = rdata;
        if (n != "") chk(n, e, d & m);
    endtask : rdc
    task wt(input logic [7:0] m);
        for (i = 0; i < 3000 && (d & m) !== m; i++) rdc(S, 8'hFF, 8'h00, "");
        if (i == 3000) begin err_count++; give_verdict; end
    endtask : wt
    initial begin
        rstn = 1'b0; wr = 1'b0; rd = 1'b0; ss_n = 1'b1; addr = 8'h00; wdata = 8'h00; d = 8'h00;
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        rdc(C, 8'hFF, spf_pkg::CTRL_RESET, "ctrl");
        rdc(S, 8'hFF, 8'h08, "stat");
        rdc(8'h20, 8'hFF, 8'h00, "unmapped");
        wrr(S, 8'h01);
        wrr(C, 8'h2A);
        wrr(D, 8'hA5);
        for (i = 0; i < 20 && sck !== 1'b1; i++) @(posedge clk) #1;
        chk("start", 8'(i <= 9), 8'h01);
        wt(8'h80);
        chk("peer rx", 8'hA5, prx);
        wrr(D, 8'h5A);
        wt(8'h20);
        rdc(S, 8'hFF, 8'hA9, "ovr stat");
        rdc(D, 8'hFF, 8'h3C, "kept byte");
        for (i = 0; i < 3000 && prx !== 8'h5A; i++) @(posedge clk);
        chk("peer rx2", 8'h5A, prx);
        wrr(S, 8'h45);
        ss_n <= 1'b0;
        repeat (4) @(posedge clk);
        #1 chk("irq", 8'h01, 8'(irq));
        ss_n <= 1'b1;
        rdc(C, 8'hFF, 8'h28, "ctrl fault");
        rdc(S, 8'h7F, 8'h5D, "stat fault");
        wrr(C, 8'h28);
        rdc(S, 8'h10, 8'h00, "fault clr");
        wrr(C, 8'h0A);
        ss_n <= 1'b0;
        repeat (3) @(posedge clk);
        #1 chk("miso oe", 8'h01, 8'(miso_oe));
        ss_n <= 1'b1;
        repeat (3) @(posedge clk);
        #1 chk("miso off", 8'h00, 8'(miso_oe));
        rdc(S, 8'h10, 8'h00, "no fault");
        wrr(C, 8'h00);
        wrr(C, 8'h02);
        ss_n <= 1'b0;
        repeat (3) @(posedge clk);
        ss_n <= 1'b1;
        rdc(S, 8'h10, 8'h10, "slave fault");
        rdc(C, 8'hFF, 8'h02, "slave spe");
        give_verdict;
    end
endmodule : tb
